// ===== include/uc_defines.vh
`ifndef UC_DEFINES_VH
`define UC_DEFINES_VH

// printed register offsets (each one is the register's index)
`define UC_OFS_TX_HOLD 24'hFFFE40
`define UC_OFS_RX_HOLD 24'hFFFE42
`define UC_OFS_IRQ_CTL 24'hFFFE44
`define UC_OFS_STATUS 24'hFFFE46
`define UC_OFS_FRAME 24'hFFFE48
`define UC_OFS_MODE1 24'hFFFE4A
`define UC_OFS_DIV_LO 24'hFFFE4C
`define UC_OFS_PRESC 24'hFFFE4E
`define UC_OFS_OVR 24'hFFFE50
`define UC_OFS_MODE2 24'hFFFE52
`define UC_OFS_SPOS 24'hFFFE54

// avalon word address width; word address equals index low byte
`define UC_ADDR_W 8

// interrupt_control fields
`define UC_IC_TX_EN 0
`define UC_IC_RX_EN 1
`define UC_IC_ERR_EN 2
`define UC_IC_FLOW_EN 3
`define UC_IC_CTS_CHG 4
`define UC_IC_CTS_LVL 5

// port_status fields
`define UC_ST_ERR 0
`define UC_ST_BRK 1
`define UC_ST_RXF 2
`define UC_ST_TXE 3
`define UC_ST_RB9 4

// frame_format fields
`define UC_FF_CHAR_LO 0
`define UC_FF_STOP 2
`define UC_FF_XB9 3
`define UC_FF_PKIND_LO 4
`define UC_FF_PON 6

// frame character codes
`define UC_CHAR_8 2'h0
`define UC_CHAR_7 2'h1
`define UC_CHAR_9 2'h2
`define UC_CHAR_LOOP 2'h3

// mode_select_one fields
`define UC_M1_ATN 0
`define UC_M1_TXDMA 1
`define UC_M1_RXDMA 2
`define UC_M1_BRK 3

// prescale_and_divisor_high fields
`define UC_PS_DIVHI_LO 0
`define UC_PS_SEL_LO 3

// reset values
`define UC_RST_BYTE 8'h00

// oversample: field value 0 means the asynchronous default of 16
`define UC_OVR_DEFAULT 5'h10
// break: receive input low for this many bit times
`define UC_BRK_BITS 8'h0A
`endif

// ===== design/uc_top.v
`timescale 1ns/1ns
// Function
// (RQ1) baud clock comes from system clock via 5-bit prescaler then 11-bit divisor
// (RQ2) prescaler code k divides by (k+1)/2, half steps supported
// (RQ3) prescaler code zero stops the serial clock: low-power state
// (RQ4) software stops the prescaler before changing the baud rate
// (RQ5) baud rate is clock over oversample times divisor-plus-one times prescale
// (RQ6) separate enables for transmit, receive and receive-error interrupts
// (RQ7) transmit interrupt while buffer empty and enabled; holding write clears empty
// (RQ8) receive interrupt while buffer full and enabled; holding read clears full
// (RQ9) receive interrupt while error flag and enabled; status read clears error
// (RQ10) flow interrupt while cts changed and enabled; control read clears it
// (RQ11) receive data and cts inputs are routed to the wakeup unit
// (RQ12) transmit and receive dma may be enabled together
// (RQ13) transmit dma requests on empty rising, and blocks transmit interrupts
// (RQ14) receive dma requests on full rising, and blocks receive-full interrupts
// (RQ15) software keeps error interrupt enabled while receive dma runs
// (RQ16) line break control holds transmit line low until cleared
// (RQ17) break reported when receive stays low ten bit times after missing stop
// (RQ18) parity only for 7 and 8 bit frames, not loopback, attention or 9-bit
// (RQ19) parity enable bit and parity kind field in frame format register
// (RQ20) parity kind: 00 odd, 01 even, 10 mark, 11 space
// (RQ21) divisor is three high bits in prescale register plus divisor low byte
// (RQ22) asynchronous mode samples sixteen clocks per bit time
// (RQ23) interrupt requests are synchronous levels, held while flag and enable set
`include "uc_defines.vh"

module uc_top (
  input wire CLK_IN,
  input wire SRST_IN,
  input wire [`UC_ADDR_W-1:0] AVS_ADDRESS_IN,
  input wire AVS_READ_IN,
  input wire AVS_WRITE_IN,
  input wire [31:0] AVS_WRITEDATA_IN,
  output reg [31:0] AVS_READDATA_OUT,
  output reg AVS_WAITREQUEST_OUT,
  input wire TX_LOAD_IN,
  input wire TX_SERIAL_IN,
  input wire RX_LOAD_IN,
  input wire [7:0] RX_DATA_IN,
  input wire RX_BIT9_IN,
  input wire RX_ERR_IN,
  input wire STOP_MISSING_IN,
  input wire RXD_IN,
  input wire CTS_N_IN,
  output reg [7:0] TX_DATA_OUT,
  output reg TX_BUF_EMPTY_OUT,
  output reg TXD_OUT,
  output reg SAMPLE_TICK_OUT,
  output reg BIT_TICK_OUT,
  output reg POWER_DOWN_OUT,
  output reg PARITY_EN_OUT,
  output reg [1:0] PARITY_KIND_OUT,
  output reg [1:0] FRAME_CHAR_OUT,
  output reg STOP_TWO_OUT,
  output reg TX_BIT9_OUT,
  output reg TX_IRQ_OUT,
  output reg RX_IRQ_OUT,
  output reg FLOW_IRQ_OUT,
  output reg TX_DMA_REQ_OUT,
  output reg RX_DMA_REQ_OUT,
  output reg WAKE_RXD_OUT,
  output reg WAKE_CTS_N_OUT
);

  // software-visible storage
  reg [7:0] tx_hold_ff;
  reg [7:0] rx_hold_ff;
  reg [3:0] irq_en_ff;
  reg [7:0] frame_ff;
  reg [7:0] mode1_ff;
  reg [7:0] div_lo_ff;
  reg [7:0] presc_ff;
  reg [7:0] ovr_ff;
  reg [7:0] mode2_ff;
  reg [7:0] spos_ff;
  // hardware flags
  reg tx_empty_ff;
  reg rx_full_ff;
  reg rx_err_ff;
  reg brk_ff;
  reg rx_b9_ff;
  reg cts_chg_ff;
  reg cts_prev_ff;
  reg tx_empty_prev_ff;
  reg rx_full_prev_ff;
  // baud chain
  reg [5:0] pre_acc_ff;
  reg pre_tick_ff;
  reg [10:0] div_cnt_ff;
  reg [4:0] ovs_cnt_ff;
  // break detector
  reg brk_arm_ff;
  reg [7:0] brk_cnt_ff;

  wire acc_rd;
  wire acc_wr;
  wire [4:0] ps_sel;
  wire [10:0] rate_divisor;
  wire [4:0] ovs_rate;
  wire tx_dma_en;
  wire rx_dma_en;

  // register index decode: word address is the low byte of the printed index
  function hit;
    input [`UC_ADDR_W-1:0] addr;
    input [23:0] ofs;
    begin
      hit = (addr == ofs[`UC_ADDR_W-1:0]);
    end
  endfunction

  // an access completes on the edge where waitrequest is seen low
  assign acc_rd = AVS_READ_IN & ~AVS_WAITREQUEST_OUT;
  assign acc_wr = AVS_WRITE_IN & ~AVS_WAITREQUEST_OUT;

  assign ps_sel = presc_ff[`UC_PS_SEL_LO+4:`UC_PS_SEL_LO];
  assign rate_divisor = {presc_ff[`UC_PS_DIVHI_LO+2:`UC_PS_DIVHI_LO], div_lo_ff}; // [RQ21]
  // oversample field zero keeps sixteen samples per bit
  assign ovs_rate = (ovr_ff[3:0] == 4'h0) ? `UC_OVR_DEFAULT : {1'b0, ovr_ff[3:0]}; // [RQ22]
  assign tx_dma_en = mode1_ff[`UC_M1_TXDMA];
  assign rx_dma_en = mode1_ff[`UC_M1_RXDMA];

  // bus slave: one wait state per access, then a single ready cycle
  always @(posedge CLK_IN) begin
    if (SRST_IN) begin
      AVS_WAITREQUEST_OUT <= 1'b1;
    end else if ((AVS_READ_IN | AVS_WRITE_IN) & AVS_WAITREQUEST_OUT) begin
      AVS_WAITREQUEST_OUT <= 1'b0;
    end else begin
      AVS_WAITREQUEST_OUT <= 1'b1;
    end
  end

  // read data registered during the wait state so it stands at the ready edge
  always @(posedge CLK_IN) begin
    if (SRST_IN) begin
      AVS_READDATA_OUT <= 32'h00000000;
    end else if (AVS_READ_IN & AVS_WAITREQUEST_OUT) begin
      AVS_READDATA_OUT <= 32'h00000000;
      if (hit(AVS_ADDRESS_IN, `UC_OFS_TX_HOLD)) begin
        AVS_READDATA_OUT[7:0] <= tx_hold_ff;
      end else if (hit(AVS_ADDRESS_IN, `UC_OFS_RX_HOLD)) begin
        AVS_READDATA_OUT[7:0] <= rx_hold_ff;
      end else if (hit(AVS_ADDRESS_IN, `UC_OFS_IRQ_CTL)) begin
        AVS_READDATA_OUT[3:0] <= irq_en_ff; // [RQ6]
        AVS_READDATA_OUT[`UC_IC_CTS_CHG] <= cts_chg_ff;
        AVS_READDATA_OUT[`UC_IC_CTS_LVL] <= cts_prev_ff;
      end else if (hit(AVS_ADDRESS_IN, `UC_OFS_STATUS)) begin
        AVS_READDATA_OUT[`UC_ST_ERR] <= rx_err_ff;
        AVS_READDATA_OUT[`UC_ST_BRK] <= brk_ff;
        AVS_READDATA_OUT[`UC_ST_RXF] <= rx_full_ff;
        AVS_READDATA_OUT[`UC_ST_TXE] <= tx_empty_ff;
        AVS_READDATA_OUT[`UC_ST_RB9] <= rx_b9_ff;
      end else if (hit(AVS_ADDRESS_IN, `UC_OFS_FRAME)) begin
        AVS_READDATA_OUT[6:0] <= frame_ff[6:0];
      end else if (hit(AVS_ADDRESS_IN, `UC_OFS_MODE1)) begin
        AVS_READDATA_OUT[7:0] <= mode1_ff;
      end else if (hit(AVS_ADDRESS_IN, `UC_OFS_DIV_LO)) begin
        AVS_READDATA_OUT[7:0] <= div_lo_ff;
      end else if (hit(AVS_ADDRESS_IN, `UC_OFS_PRESC)) begin
        AVS_READDATA_OUT[7:0] <= presc_ff;
      end else if (hit(AVS_ADDRESS_IN, `UC_OFS_OVR)) begin
        AVS_READDATA_OUT[7:0] <= ovr_ff;
      end else if (hit(AVS_ADDRESS_IN, `UC_OFS_MODE2)) begin
        AVS_READDATA_OUT[7:0] <= mode2_ff;
      end else if (hit(AVS_ADDRESS_IN, `UC_OFS_SPOS)) begin
        AVS_READDATA_OUT[7:0] <= spos_ff;
      end
    end
  end

  // software writes; unmapped writes are dropped
  always @(posedge CLK_IN) begin
    if (SRST_IN) begin
      tx_hold_ff <= `UC_RST_BYTE;
      irq_en_ff <= 4'h0;
      frame_ff <= `UC_RST_BYTE;
      mode1_ff <= `UC_RST_BYTE;
      div_lo_ff <= `UC_RST_BYTE;
      presc_ff <= `UC_RST_BYTE;
      ovr_ff <= `UC_RST_BYTE;
      mode2_ff <= `UC_RST_BYTE;
      spos_ff <= `UC_RST_BYTE;
    end else if (acc_wr) begin
      if (hit(AVS_ADDRESS_IN, `UC_OFS_TX_HOLD)) begin
        tx_hold_ff <= AVS_WRITEDATA_IN[7:0];
      end
      if (hit(AVS_ADDRESS_IN, `UC_OFS_IRQ_CTL)) begin
        irq_en_ff <= AVS_WRITEDATA_IN[3:0]; // [RQ6]
      end
      if (hit(AVS_ADDRESS_IN, `UC_OFS_FRAME)) begin
        frame_ff <= {1'b0, AVS_WRITEDATA_IN[6:0]}; // [RQ19]
      end
      if (hit(AVS_ADDRESS_IN, `UC_OFS_MODE1)) begin
        mode1_ff <= AVS_WRITEDATA_IN[7:0]; // [RQ12]
      end
      // changing the rate while running may corrupt frames in flight
      if (hit(AVS_ADDRESS_IN, `UC_OFS_DIV_LO)) begin
        div_lo_ff <= AVS_WRITEDATA_IN[7:0]; // [RQ4]
      end
      if (hit(AVS_ADDRESS_IN, `UC_OFS_PRESC)) begin
        presc_ff <= AVS_WRITEDATA_IN[7:0];
      end
      if (hit(AVS_ADDRESS_IN, `UC_OFS_OVR)) begin
        ovr_ff <= AVS_WRITEDATA_IN[7:0];
      end
      if (hit(AVS_ADDRESS_IN, `UC_OFS_MODE2)) begin
        mode2_ff <= AVS_WRITEDATA_IN[7:0];
      end
      if (hit(AVS_ADDRESS_IN, `UC_OFS_SPOS)) begin
        spos_ff <= AVS_WRITEDATA_IN[7:0];
      end
    end
  end

  // transmit empty: shifter load sets, holding write clears; set wins
  always @(posedge CLK_IN) begin
    if (SRST_IN) begin
      tx_empty_ff <= 1'b1;
    end else if (TX_LOAD_IN) begin
      tx_empty_ff <= 1'b1;
    end else if (acc_wr & hit(AVS_ADDRESS_IN, `UC_OFS_TX_HOLD)) begin
      tx_empty_ff <= 1'b0; // [RQ7]
    end
  end

  // receive holding: a new character sets full, a software read clears it
  always @(posedge CLK_IN) begin
    if (SRST_IN) begin
      rx_hold_ff <= `UC_RST_BYTE;
      rx_b9_ff <= 1'b0;
      rx_full_ff <= 1'b0;
    end else if (RX_LOAD_IN) begin
      rx_hold_ff <= RX_DATA_IN;
      rx_b9_ff <= RX_BIT9_IN;
      rx_full_ff <= 1'b1;
    end else begin
      if (acc_wr & hit(AVS_ADDRESS_IN, `UC_OFS_RX_HOLD)) begin
        rx_hold_ff <= AVS_WRITEDATA_IN[7:0];
      end
      if (acc_rd & hit(AVS_ADDRESS_IN, `UC_OFS_RX_HOLD)) begin
        rx_full_ff <= 1'b0; // [RQ8]
      end
    end
  end

  // error and break flags: cleared by a status read, new events win
  always @(posedge CLK_IN) begin
    if (SRST_IN) begin
      rx_err_ff <= 1'b0;
      brk_ff <= 1'b0;
    end else begin
      if (RX_ERR_IN | (brk_arm_ff & ~RXD_IN & (brk_cnt_ff == 8'h00))) begin
        rx_err_ff <= 1'b1;
      end else if (acc_rd & hit(AVS_ADDRESS_IN, `UC_OFS_STATUS)) begin
        rx_err_ff <= 1'b0; // [RQ9]
      end
      if (brk_arm_ff & ~RXD_IN & (brk_cnt_ff == 8'h00)) begin
        brk_ff <= 1'b1; // [RQ17]
      end else if (acc_rd & hit(AVS_ADDRESS_IN, `UC_OFS_STATUS)) begin
        brk_ff <= 1'b0;
      end
    end
  end

  // break watch: armed by a missing stop bit, counts samples while line low
  always @(posedge CLK_IN) begin
    if (SRST_IN) begin
      brk_arm_ff <= 1'b0;
      brk_cnt_ff <= 8'h00;
    end else if (STOP_MISSING_IN & ~RXD_IN) begin
      brk_arm_ff <= 1'b1;
      brk_cnt_ff <= `UC_BRK_BITS * {3'b000, ovs_rate}; // [RQ17]
    end else if (RXD_IN | (brk_cnt_ff == 8'h00)) begin
      brk_arm_ff <= 1'b0; // one report per low stretch
      brk_cnt_ff <= 8'h00;
    end else if (brk_arm_ff & SAMPLE_TICK_OUT) begin
      brk_cnt_ff <= brk_cnt_ff - 8'h01;
    end
  end

  // cts change tracking; a read of interrupt_control clears, change wins
  always @(posedge CLK_IN) begin
    if (SRST_IN) begin
      cts_prev_ff <= CTS_N_IN; // track the pin so release shows no false change
      cts_chg_ff <= 1'b0;
    end else begin
      cts_prev_ff <= CTS_N_IN;
      if (CTS_N_IN != cts_prev_ff) begin
        cts_chg_ff <= 1'b1;
      end else if (acc_rd & hit(AVS_ADDRESS_IN, `UC_OFS_IRQ_CTL)) begin
        cts_chg_ff <= 1'b0; // [RQ10]
      end
    end
  end

  // prescaler in half steps: add 2 per clock, wrap at code+1 [RQ1] [RQ2]
  // averages clock*2/(code+1); half ratios alternate between two spacings
  always @(posedge CLK_IN) begin
    if (SRST_IN | (ps_sel == 5'h00)) begin
      pre_acc_ff <= 6'h00; // [RQ3]
      pre_tick_ff <= 1'b0;
    end else if ((pre_acc_ff + 6'h02) >= ({1'b0, ps_sel} + 6'h01)) begin
      pre_acc_ff <= pre_acc_ff + 6'h02 - ({1'b0, ps_sel} + 6'h01);
      pre_tick_ff <= 1'b1;
    end else begin
      pre_acc_ff <= pre_acc_ff + 6'h02;
      pre_tick_ff <= 1'b0;
    end
  end

  // divisor stage counts divisor+1 prescaler ticks [RQ1] [RQ21]
  always @(posedge CLK_IN) begin
    if (SRST_IN | (ps_sel == 5'h00)) begin
      div_cnt_ff <= 11'h000;
      SAMPLE_TICK_OUT <= 1'b0;
    end else if (pre_tick_ff & (div_cnt_ff >= rate_divisor)) begin
      div_cnt_ff <= 11'h000;
      SAMPLE_TICK_OUT <= 1'b1;
    end else begin
      if (pre_tick_ff) begin
        div_cnt_ff <= div_cnt_ff + 11'h001;
      end
      SAMPLE_TICK_OUT <= 1'b0;
    end
  end

  // bit tick every oversample count of sample ticks [RQ5] [RQ22]
  always @(posedge CLK_IN) begin
    if (SRST_IN | (ps_sel == 5'h00)) begin
      ovs_cnt_ff <= 5'h00;
      BIT_TICK_OUT <= 1'b0;
    end else if (SAMPLE_TICK_OUT & ((ovs_cnt_ff + 5'h01) >= ovs_rate)) begin
      ovs_cnt_ff <= 5'h00;
      BIT_TICK_OUT <= 1'b1;
    end else begin
      if (SAMPLE_TICK_OUT) begin
        ovs_cnt_ff <= ovs_cnt_ff + 5'h01;
      end
      BIT_TICK_OUT <= 1'b0;
    end
  end

  // flag edges for dma requests
  always @(posedge CLK_IN) begin
    if (SRST_IN) begin
      tx_empty_prev_ff <= 1'b1;
      rx_full_prev_ff <= 1'b0;
      TX_DMA_REQ_OUT <= 1'b0;
      RX_DMA_REQ_OUT <= 1'b0;
    end else begin
      tx_empty_prev_ff <= tx_empty_ff;
      rx_full_prev_ff <= rx_full_ff;
      TX_DMA_REQ_OUT <= tx_dma_en & tx_empty_ff & ~tx_empty_prev_ff; // [RQ13] [RQ12]
      RX_DMA_REQ_OUT <= rx_dma_en & rx_full_ff & ~rx_full_prev_ff; // [RQ14] [RQ12]
    end
  end

  // interrupt levels, one clock behind their flags and enables
  always @(posedge CLK_IN) begin
    if (SRST_IN) begin
      TX_IRQ_OUT <= 1'b0;
      RX_IRQ_OUT <= 1'b0;
      FLOW_IRQ_OUT <= 1'b0;
    end else begin
      TX_IRQ_OUT <= tx_empty_ff & irq_en_ff[`UC_IC_TX_EN] & ~tx_dma_en; // [RQ7] [RQ13] [RQ23]
      // error interrupt stays live under receive dma so errors still surface
      RX_IRQ_OUT <= (rx_full_ff & irq_en_ff[`UC_IC_RX_EN] & ~rx_dma_en) | // [RQ8] [RQ14]
                    (rx_err_ff & irq_en_ff[`UC_IC_ERR_EN]); // [RQ9] [RQ15] [RQ23]
      FLOW_IRQ_OUT <= cts_chg_ff & irq_en_ff[`UC_IC_FLOW_EN]; // [RQ10] [RQ23]
    end
  end

  // line and frame controls for the shifters and the wakeup unit
  always @(posedge CLK_IN) begin
    if (SRST_IN) begin
      TXD_OUT <= 1'b1;
      TX_DATA_OUT <= `UC_RST_BYTE;
      TX_BUF_EMPTY_OUT <= 1'b1;
      POWER_DOWN_OUT <= 1'b1;
      PARITY_EN_OUT <= 1'b0;
      PARITY_KIND_OUT <= 2'h0;
      FRAME_CHAR_OUT <= `UC_CHAR_8;
      STOP_TWO_OUT <= 1'b0;
      TX_BIT9_OUT <= 1'b0;
      WAKE_RXD_OUT <= 1'b1;
      WAKE_CTS_N_OUT <= 1'b1;
    end else begin
      TXD_OUT <= TX_SERIAL_IN & ~mode1_ff[`UC_M1_BRK]; // [RQ16]
      TX_DATA_OUT <= tx_hold_ff;
      TX_BUF_EMPTY_OUT <= tx_empty_ff;
      POWER_DOWN_OUT <= (ps_sel == 5'h00); // [RQ3]
      PARITY_EN_OUT <= frame_ff[`UC_FF_PON] & ~mode1_ff[`UC_M1_ATN] & // [RQ18] [RQ19]
                       ((frame_ff[1:0] == `UC_CHAR_8) | (frame_ff[1:0] == `UC_CHAR_7));
      PARITY_KIND_OUT <= frame_ff[`UC_FF_PKIND_LO+1:`UC_FF_PKIND_LO]; // [RQ20]
      FRAME_CHAR_OUT <= frame_ff[1:0];
      STOP_TWO_OUT <= frame_ff[`UC_FF_STOP];
      TX_BIT9_OUT <= frame_ff[`UC_FF_XB9];
      WAKE_RXD_OUT <= RXD_IN; // [RQ11]
      WAKE_CTS_N_OUT <= CTS_N_IN; // [RQ11]
    end
  end

endmodule

// ===== tb/uc_top_assertions.sv
`timescale 1ns/1ns
`include "uc_defines.vh"
module uc_top_chk (
  input wire CLK_IN,
  input wire SRST_IN,
  input wire AVS_READ_IN,
  input wire AVS_WRITE_IN,
  input wire AVS_WAITREQUEST_OUT,
  input wire TX_SERIAL_IN,
  input wire RXD_IN,
  input wire TX_BUF_EMPTY_OUT,
  input wire TXD_OUT,
  input wire SAMPLE_TICK_OUT,
  input wire POWER_DOWN_OUT,
  input wire PARITY_EN_OUT,
  input wire [1:0] FRAME_CHAR_OUT,
  input wire TX_IRQ_OUT,
  input wire RX_IRQ_OUT,
  input wire TX_DMA_REQ_OUT,
  input wire RX_DMA_REQ_OUT,
  input wire WAKE_RXD_OUT
);
  default clocking dc @(posedge CLK_IN); endclocking
  default disable iff (SRST_IN);
  // a request seen with waitrequest high completes one edge later
  property p_bus_answer;
    (AVS_READ_IN || AVS_WRITE_IN) && AVS_WAITREQUEST_OUT |=> !AVS_WAITREQUEST_OUT;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("bus answer late");
  property p_bus_gap;
    !AVS_WAITREQUEST_OUT |=> AVS_WAITREQUEST_OUT;
  endproperty
  a_bus_gap: assert property (p_bus_gap) else $error("waitrequest low too long");
  // a high line can only come from a high shifter bit
  property p_txd_low;
    TXD_OUT && !$past(SRST_IN) |-> $past(TX_SERIAL_IN);
  endproperty
  a_txd_low: assert property (p_txd_low) else $error("transmit line high wrongly");
  property p_wake_copy;
    !$past(SRST_IN) |-> WAKE_RXD_OUT == $past(RXD_IN);
  endproperty
  a_wake_copy: assert property (p_wake_copy) else $error("wakeup copy wrong");
  property p_tx_irq;
    TX_IRQ_OUT |-> TX_BUF_EMPTY_OUT;
  endproperty
  a_tx_irq: assert property (p_tx_irq) else $error("transmit irq without empty");
  // dma request is a lone pulse and masks the transmit irq
  property p_tx_dma;
    TX_DMA_REQ_OUT |-> !TX_IRQ_OUT && TX_BUF_EMPTY_OUT && !$past(TX_BUF_EMPTY_OUT)
      ##1 !TX_DMA_REQ_OUT;
  endproperty
  a_tx_dma: assert property (p_tx_dma) else $error("transmit dma request wrong");
  property p_rx_dma;
    RX_DMA_REQ_OUT |-> !RX_IRQ_OUT ##1 !RX_DMA_REQ_OUT;
  endproperty
  a_rx_dma: assert property (p_rx_dma) else $error("receive dma request wrong");
  property p_pd_quiet;
    POWER_DOWN_OUT && $past(POWER_DOWN_OUT) |-> !SAMPLE_TICK_OUT;
  endproperty
  a_pd_quiet: assert property (p_pd_quiet) else $error("tick while stopped");
  property p_parity;
    PARITY_EN_OUT |-> FRAME_CHAR_OUT != `UC_CHAR_9 && FRAME_CHAR_OUT != `UC_CHAR_LOOP;
  endproperty
  a_parity: assert property (p_parity) else $error("parity in nine bit frame");
endmodule

bind uc_top uc_top_chk u_chk (.CLK_IN(CLK_IN), .SRST_IN(SRST_IN), .AVS_READ_IN(AVS_READ_IN),
  .AVS_WRITE_IN(AVS_WRITE_IN), .AVS_WAITREQUEST_OUT(AVS_WAITREQUEST_OUT), .RXD_IN(RXD_IN),
  .TX_SERIAL_IN(TX_SERIAL_IN), .TX_BUF_EMPTY_OUT(TX_BUF_EMPTY_OUT), .TXD_OUT(TXD_OUT),
  .SAMPLE_TICK_OUT(SAMPLE_TICK_OUT), .POWER_DOWN_OUT(POWER_DOWN_OUT),
  .PARITY_EN_OUT(PARITY_EN_OUT), .FRAME_CHAR_OUT(FRAME_CHAR_OUT), .TX_IRQ_OUT(TX_IRQ_OUT),
  .RX_IRQ_OUT(RX_IRQ_OUT), .TX_DMA_REQ_OUT(TX_DMA_REQ_OUT), .RX_DMA_REQ_OUT(RX_DMA_REQ_OUT),
  .WAKE_RXD_OUT(WAKE_RXD_OUT));

// ===== tb/uc_far_model.sv
`timescale 1ns/1ns
module uc_far_model (
  input wire clk_in,
  output reg tx_load_out,
  output reg tx_serial_out,
  output reg rx_load_out,
  output reg [7:0] rx_data_out,
  output reg rx_err_out,
  output reg stop_missing_out,
  output reg rxd_out,
  output reg cts_n_out
);
  // idle: line high, peer ready
  initial begin
    tx_load_out = 1'b0;
    tx_serial_out = 1'b1;
    rx_load_out = 1'b0;
    rx_data_out = 8'h00;
    rx_err_out = 1'b0;
    stop_missing_out = 1'b0;
    rxd_out = 1'b1;
    cts_n_out = 1'b0;
  end
  // shifter bit keeps toggling so a stuck transmit line shows up
  always @(posedge clk_in) begin
    tx_serial_out <= ~tx_serial_out;
  end
  // one strobe; data scrambled after so stale bytes are not reused
  task strobe(input tk, input ld, input er, input [7:0] d);
    begin
      @(posedge clk_in);
      tx_load_out <= tk;
      rx_load_out <= ld;
      rx_err_out <= er;
      rx_data_out <= d;
      @(posedge clk_in);
      tx_load_out <= 1'b0;
      rx_load_out <= 1'b0;
      rx_err_out <= 1'b0;
      rx_data_out <= ~d;
    end
  endtask
  task cts_flip;
    begin
      @(posedge clk_in);
      cts_n_out <= ~cts_n_out;
    end
  endtask
  // missing stop bit, then the line stays low for n cycles
  task hold_low(input integer n);
    begin
      @(posedge clk_in);
      stop_missing_out <= 1'b1;
      rxd_out <= 1'b0;
      @(posedge clk_in);
      stop_missing_out <= 1'b0;
      repeat (n) @(posedge clk_in);
      rxd_out <= 1'b1;
    end
  endtask
endmodule

// ===== tb/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  localparam [7:0] A_TXH = 8'h40, A_RXH = 8'h42, A_ICT = 8'h44, A_STA = 8'h46;
  localparam [7:0] A_FRM = 8'h48, A_MD1 = 8'h4A, A_DIV = 8'h4C, A_PSR = 8'h4E, A_OVR = 8'h50;
  localparam [31:0] CODES = 32'h0011FC41;
  localparam [23:0] OVRS = 24'h113021;
  reg clk, rst, rd, wr, t1;
  reg [7:0] addr, v, dv;
  reg [31:0] wdata, q;
  integer err_count, cmp_count, i, e, o, n_s, n_b, n_td, n_rd;
  wire [31:0] rdata;
  wire [7:0] rx_data, tx_data;
  wire [1:0] pkind, fchar;
  wire wreq, tx_load, tx_ser, rx_load, rx_err, stop_miss, rxd, cts_n, txe, txd;
  wire s_tick, b_tick, pdn, parity_on, tx_irq, rx_irq, fl_irq, tx_dreq, rx_dreq, s2, b9, wcts;

  uc_top u_dut (.CLK_IN(clk), .SRST_IN(rst), .AVS_ADDRESS_IN(addr), .AVS_READ_IN(rd),
    .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wdata), .AVS_READDATA_OUT(rdata),
    .AVS_WAITREQUEST_OUT(wreq), .TX_LOAD_IN(tx_load), .TX_SERIAL_IN(tx_ser),
    .RX_LOAD_IN(rx_load), .RX_DATA_IN(rx_data), .RX_BIT9_IN(rx_data[0]), .RX_ERR_IN(rx_err),
    .STOP_MISSING_IN(stop_miss), .RXD_IN(rxd), .CTS_N_IN(cts_n), .TX_DATA_OUT(tx_data),
    .TX_BUF_EMPTY_OUT(txe), .TXD_OUT(txd), .SAMPLE_TICK_OUT(s_tick), .BIT_TICK_OUT(b_tick),
    .POWER_DOWN_OUT(pdn), .PARITY_EN_OUT(parity_on), .PARITY_KIND_OUT(pkind),
    .FRAME_CHAR_OUT(fchar), .STOP_TWO_OUT(s2), .TX_BIT9_OUT(b9), .TX_IRQ_OUT(tx_irq),
    .RX_IRQ_OUT(rx_irq), .FLOW_IRQ_OUT(fl_irq), .TX_DMA_REQ_OUT(tx_dreq),
    .RX_DMA_REQ_OUT(rx_dreq), .WAKE_RXD_OUT(), .WAKE_CTS_N_OUT(wcts));
  uc_far_model u_far (.clk_in(clk), .tx_load_out(tx_load), .tx_serial_out(tx_ser),
    .rx_load_out(rx_load), .rx_data_out(rx_data), .rx_err_out(rx_err),
    .stop_missing_out(stop_miss), .rxd_out(rxd), .cts_n_out(cts_n));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // event counters; tolerance in the rate checks covers the reset race
  always @(posedge clk) begin
    n_s = n_s + (s_tick === 1'b1);
    n_b = n_b + (b_tick === 1'b1);
    n_td = n_td + (tx_dreq === 1'b1);
    n_rd = n_rd + (rx_dreq === 1'b1);
  end

  task chk(input [31:0] seen, input [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
        err_count = err_count + 1;
        $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  // request held until waitrequest is sampled low
  task bus(input w, input [7:0] a, input [7:0] d);
    begin
      @(posedge clk);
      addr <= a;
      wdata <= {24'h000000, d};
      rd <= !w;
      wr <= w;
      @(posedge clk);
      // only the watchdog ends a wait that never completes
      while (wreq !== 1'b0) @(posedge clk);
      q = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
    end
  endtask
  task rchk(input [7:0] a, input [31:0] exp);
    begin
      bus(1'b0, a, 8'h00);
      chk(q, exp);
    end
  endtask
  task settle;
    repeat (3) @(posedge clk);
  endtask
  // ticks seen in w cycles for code k and divisor-plus-one n
  function integer ticks(input integer w, input integer k, input integer n);
    ticks = (k == 0) ? 0 : (w * 2) / ((k + 1) * n);
  endfunction
  function exp_pen(input [7:0] f);
    exp_pen = f[6] && (f[1:0] < 2'h2);
  endfunction

  task summarize;
    begin
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    err_count = err_count + 1;
    summarize;
  end

  initial begin
    {rd, wr, addr, wdata, err_count, cmp_count, n_s, n_b, n_td, n_rd} = 0;
    rst = 1'b1;
    i = $urandom(32'h741E922B);
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    for (i = 8'h40; i <= 8'h54; i = i + 2) rchk(i, (i == A_STA) ? 8'h08 : 8'h00);
    rchk(8'h60, 8'h00);
    chk(pdn, 1'b1);
    // every char and parity code, random extras in the spare bits
    for (i = 0; i < 16; i = i + 1) begin
      v = ($urandom & 8'h0C) | {2'b01, i[3:2], 2'b00, i[1:0]};
      bus(1'b1, A_FRM, v);
      rchk(A_FRM, v);
      chk(parity_on, exp_pen(v));
      chk(pkind, v[5:4]);
      chk({fchar, s2, b9}, {v[1:0], v[2], v[3]});
    end
    bus(1'b1, A_FRM, 8'h40);
    bus(1'b1, A_MD1, 8'h01);
    settle;
    chk(parity_on, 1'b0);
    bus(1'b1, A_MD1, 8'h00);
    // rate table; prescaler stopped before each change
    for (i = 0; i < 6; i = i + 1) begin
      dv = $urandom % 4;
      o = (OVRS[i*4 +: 4] == 0) ? 16 : OVRS[i*4 +: 4];
      bus(1'b1, A_PSR, 8'h00);
      bus(1'b1, A_DIV, dv);
      bus(1'b1, A_OVR, {4'h0, OVRS[i*4 +: 4]});
      bus(1'b1, A_PSR, {CODES[i*5 +: 5], 2'b00, i == 4});
      settle;
      n_s = 0;
      n_b = 0;
      repeat (600) @(posedge clk);
      e = ticks(600, CODES[i*5 +: 5], dv + 1 + ((i == 4) ? 256 : 0));
      chk(n_s >= e - 1 && n_s <= e + 1, 1'b1);
      chk(n_b >= e / o - 1 && n_b <= e / o + 1, 1'b1);
    end
    bus(1'b1, A_OVR, 8'h01);
    bus(1'b1, A_DIV, 8'h00);
    bus(1'b1, A_PSR, 8'h08);
    u_far.hold_low(5);
    rchk(A_STA, 8'h08);
    u_far.hold_low(14);
    rchk(A_STA, 8'h0B);
    rchk(A_STA, 8'h08);
    // transmit irq: set, cleared by holding write, back on load
    bus(1'b1, A_ICT, 8'h01);
    settle;
    chk(tx_irq, 1'b1);
    v = $urandom;
    bus(1'b1, A_TXH, v);
    settle;
    chk({tx_data, txe, tx_irq}, {v, 2'b00});
    u_far.strobe(1'b1, 1'b0, 1'b0, 8'h00);
    settle;
    chk(tx_irq, 1'b1);
    bus(1'b1, A_ICT, 8'h02);
    settle;
    chk(tx_irq, 1'b0);
    v = $urandom;
    u_far.strobe(1'b0, 1'b1, 1'b0, v);
    settle;
    chk(rx_irq, 1'b1);
    rchk(A_RXH, v);
    settle;
    chk(rx_irq, 1'b0);
    bus(1'b1, A_ICT, 8'h04);
    u_far.strobe(1'b0, 1'b0, 1'b1, 8'h00);
    settle;
    chk(rx_irq, 1'b1);
    rchk(A_STA, {3'b000, v[0], 4'h9});
    settle;
    chk(rx_irq, 1'b0);
    bus(1'b1, A_ICT, 8'h08);
    u_far.cts_flip;
    settle;
    chk(fl_irq, 1'b1);
    chk(wcts, cts_n);
    bus(1'b0, A_ICT, 8'h00);
    chk(q & 8'h1F, 8'h18);
    settle;
    chk(fl_irq, 1'b0);
    // both dma channels; a second char while full gives no request
    bus(1'b1, A_ICT, 8'h07);
    bus(1'b1, A_MD1, 8'h06);
    n_td = 0;
    n_rd = 0;
    bus(1'b1, A_TXH, $urandom);
    u_far.strobe(1'b1, 1'b1, 1'b0, 8'h3C);
    u_far.strobe(1'b0, 1'b1, 1'b0, 8'hC3);
    settle;
    chk({n_td[3:0], n_rd[3:0], tx_irq, rx_irq}, 10'h044);
    rchk(A_RXH, 8'hC3);
    bus(1'b1, A_MD1, 8'h08);
    settle;
    chk({tx_irq, txd}, 2'b10);
    repeat (5) @(posedge clk);
    chk(txd, 1'b0);
    bus(1'b1, A_MD1, 8'h00);
    settle;
    t1 = txd;
    @(posedge clk);
    chk(t1 ^ txd, 1'b1);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rchk(A_PSR, 8'h00);
    chk(pdn, 1'b1);
    summarize;
  end
endmodule
